// ---- bor_consts.svh ----
`ifndef BOR_CONSTS_SVH
`define BOR_CONSTS_SVH

// Endian select codes held in option memory.
`define BOR_ENDIAN_BIG        3'h0
`define BOR_ENDIAN_LITTLE     3'h7

// Code flash blocks that trusted execute-only memory covers.
`define BOR_TRUSTED_BLOCK_A   4'h8
`define BOR_TRUSTED_BLOCK_B   4'h9

// Single common reset vector: the fetch address of the reset program counter.
`define BOR_RESET_VECTOR      32'hFFFFFFFC

// Least time the internal reset is held after a source, and its cycle count at 100 MHz.
`define BOR_HOLD_NS           100
`define BOR_CLK_NS            10
`define BOR_HOLD_CYCLES       ((`BOR_HOLD_NS + `BOR_CLK_NS - 1) / `BOR_CLK_NS)

// Reset source indices, highest initialization scope first.
`define BOR_SRC_PIN           0
`define BOR_SRC_POR           1
`define BOR_SRC_LVD0          2
`define BOR_SRC_IWDT          3
`define BOR_SRC_WDT           4
`define BOR_SRC_LVD1          5
`define BOR_SRC_LVD2          6
`define BOR_SRC_DSTBY         7
`define BOR_SRC_SW            8

// For each detection flag, the sources that clear it (bit n = source n).
`define BOR_CLR_POR           9'h001
`define BOR_CLR_LVD0          9'h003
`define BOR_CLR_IWDT          9'h087
`define BOR_CLR_WDT           9'h08F
`define BOR_CLR_LVD1          9'h01F
`define BOR_CLR_LVD2          9'h03F
`define BOR_CLR_DSTBY         9'h07F
`define BOR_CLR_SW            9'h0FF
`define BOR_CLR_COLD_WARM     9'h002

// Protect bit that unlocks the software reset register.
`define BOR_PROT_SWRST_BIT    1

`endif

// ---- bor_pkg.sv ----
`default_nettype none
package bor_pkg;

    typedef enum logic [1:0] {
        BOR_RUN,
        BOR_HOLD,
        BOR_VECTOR
    } bor_state_t;

    // Options as read from non-volatile option memory.
    typedef struct packed {
        logic [2:0]   endian_select_field;
        logic         programmer_command_control;
        logic [127:0] debugger_id_code_store;
        logic         trusted_execute_only_memory;
    } bor_opts_t;

    // One memory access to be checked.
    typedef struct packed {
        logic       valid;
        logic       fetch;
        logic       outside;
        logic       external;
        logic [2:0] cs;
        logic [3:0] block;
    } bor_access_t;

    // Detection flags, one per source; the pin source has no flag of its own.
    typedef struct packed {
        logic cold_warm_start_flag;
        logic [8:0] detect;
    } bor_status_t;

    typedef struct packed {
        bor_state_t  state;
        logic [7:0]  hold_cnt;
        bor_opts_t   opts;
        bor_status_t status;
        logic [7:0]  write_protect_register;
        logic        pc_load;
        logic        dbg_connected;
        logic        id_refused;
        logic        cmd_accept;
        logic        cmd_refuse;
        logic        acc_done;
        logic        acc_denied;
        logic        acc_big_endian;
        logic        acc_code_mismatch;
    } bor_regs_t;

endpackage

`default_nettype wire

// ---- bor_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "bor_consts.svh"

// How it works
// - Instruction fetches are always little-endian; data follows the configured order.
// - Chip data endianness comes from the three-bit option field read at reset.
// - Each external chip-select region has its own data endianness setting.
// - With trusted memory on, outside reads of flash blocks 8 and 9 are refused.
// - Trusted areas allow only instruction fetches; internal data reads are refused too.
// - Serial programmer commands are accepted only when the option enables them.
// - Connection is granted only on exact match with the stored ID code.
// - Nine reset sources: pin, power-on, three monitors, standby, two watchdogs, software.
// - Every reset source leads to the one common reset vector.
// - The reset cause is kept in three readable reset status registers.
// - Reset loads only the program counter; no stack pointer is loaded.
// - Cold/warm flag is cleared only by power-on; software writes one for warm.
// - Software reset writes are ignored unless protect bit one is set.
module bor_ctrl
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [8:0]           reset_src,
    input  wire bor_pkg::bor_opts_t   opt_mem,
    input  wire logic [7:0]           cs_big_endian,
    input  wire bor_pkg::bor_access_t access,
    input  wire logic                 id_valid,
    input  wire logic [127:0]         id_code,
    input  wire logic                 cmd_valid,
    input  wire logic                 prot_wr,
    input  wire logic [7:0]           prot_wdata,
    input  wire logic                 swrst_wr,
    input  wire logic                 cold_warm_wr,
    input  wire logic [8:0]           flag_clear,
    output logic                      sys_reset,
    output logic                      pc_load,
    output logic [31:0]               vector_addr,
    output logic                      stack_ptr_load,
    output logic [2:0]                active_endian,
    output logic                      dbg_connected,
    output logic                      id_refused,
    output logic                      cmd_accept,
    output logic                      cmd_refuse,
    output logic                      acc_done,
    output logic                      acc_denied,
    output logic                      acc_big_endian,
    output logic                      acc_code_mismatch,
    output logic [7:0]                reset_status_zero,
    output logic [7:0]                reset_status_one,
    output logic [7:0]                reset_status_two,
    output logic [7:0]                write_protect_register
);

    // ****************************************************************
    // State
    // ****************************************************************
    bor_pkg::bor_regs_t r_q;
    bor_pkg::bor_regs_t r_d;

    logic [8:0] src_all;
    logic [8:0] src_win;
    logic [8:0] clr_mask [0:8];
    logic       chip_big;
    logic       trusted_hit;
    logic       region_big;

    assign clr_mask[`BOR_SRC_PIN]   = 9'h000;
    assign clr_mask[`BOR_SRC_POR]   = `BOR_CLR_POR;
    assign clr_mask[`BOR_SRC_LVD0]  = `BOR_CLR_LVD0;
    assign clr_mask[`BOR_SRC_IWDT]  = `BOR_CLR_IWDT;
    assign clr_mask[`BOR_SRC_WDT]   = `BOR_CLR_WDT;
    assign clr_mask[`BOR_SRC_LVD1]  = `BOR_CLR_LVD1;
    assign clr_mask[`BOR_SRC_LVD2]  = `BOR_CLR_LVD2;
    assign clr_mask[`BOR_SRC_DSTBY] = `BOR_CLR_DSTBY;
    assign clr_mask[`BOR_SRC_SW]    = `BOR_CLR_SW;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        r_d = r_q;
        r_d.pc_load    = 1'b0;
        r_d.id_refused = 1'b0;
        r_d.cmd_accept = 1'b0;
        r_d.cmd_refuse = 1'b0;
        r_d.acc_done   = 1'b0;

        // A software reset write counts only while the protect bit is set; the reset_src bit is not gated.
        src_all = reset_src;
        src_all[`BOR_SRC_SW] = reset_src[`BOR_SRC_SW]
            | (swrst_wr & r_q.write_protect_register[`BOR_PROT_SWRST_BIT]);

        // Simultaneous sources: the one of highest scope wins.
        src_win = 9'h000;
        for (int i = 8; i >= 0; i--)
        begin
            if (src_all[i])
            begin
                src_win = 9'h000;
                src_win[i] = 1'b1;
            end
        end

        // Software clears first, so a hardware set in the same cycle wins.
        r_d.status.detect = r_q.status.detect & ~flag_clear;
        if (cold_warm_wr)
        begin
            r_d.status.cold_warm_start_flag = 1'b1;
        end
        if (prot_wr)
        begin
            r_d.write_protect_register = prot_wdata;
        end

        if (src_win != 9'h000)
        begin
            for (int f = 1; f < 9; f++)
            begin
                if ((clr_mask[f] & src_win) != 9'h000)
                begin
                    r_d.status.detect[f] = 1'b0;
                end
            end
            if ((src_win & `BOR_CLR_COLD_WARM) != 9'h000)
            begin
                r_d.status.cold_warm_start_flag = 1'b0;
            end
            r_d.status.detect = r_d.status.detect | (src_win & 9'h1FE);
            r_d.write_protect_register = 8'h00;
            r_d.dbg_connected = 1'b0;
            r_d.acc_denied = 1'b0;
            r_d.acc_big_endian = 1'b0;
            r_d.acc_code_mismatch = 1'b0;
            r_d.state = bor_pkg::BOR_HOLD;
            r_d.hold_cnt = 8'h00;
        end
        else
        begin
            case (r_q.state)
                bor_pkg::BOR_HOLD:
                begin
                    if (r_q.hold_cnt == 8'(`BOR_HOLD_CYCLES - 1))
                    begin
                        r_d.opts  = opt_mem;
                        r_d.state = bor_pkg::BOR_VECTOR;
                    end
                    else
                    begin
                        r_d.hold_cnt = r_q.hold_cnt + 8'h01;
                    end
                end
                bor_pkg::BOR_VECTOR:
                begin
                    // Only the program counter comes from the fixed vector.
                    r_d.pc_load = 1'b1;
                    r_d.state   = bor_pkg::BOR_RUN;
                end
                bor_pkg::BOR_RUN:
                begin
                    if (id_valid)
                    begin
                        if (id_code == r_q.opts.debugger_id_code_store)
                        begin
                            r_d.dbg_connected = 1'b1;
                        end
                        else
                        begin
                            r_d.dbg_connected = 1'b0;
                            r_d.id_refused    = 1'b1;
                        end
                    end
                    if (cmd_valid)
                    begin
                        // Commands need both the enable option and an authenticated tool.
                        if (r_q.opts.programmer_command_control && r_q.dbg_connected)
                        begin
                            r_d.cmd_accept = 1'b1;
                        end
                        else
                        begin
                            r_d.cmd_refuse = 1'b1;
                        end
                    end
                    if (access.valid)
                    begin
                        r_d.acc_done = 1'b1;
                        r_d.acc_denied = trusted_hit && (!access.fetch || access.outside);
                        r_d.acc_big_endian = !access.fetch && (access.external ? region_big : chip_big);
                        r_d.acc_code_mismatch = access.fetch && access.external && (region_big != chip_big);
                    end
                end
                default:
                begin
                    r_d.state = bor_pkg::BOR_HOLD;
                end
            endcase
        end
    end

    // ****************************************************************
    // Access decode
    // ****************************************************************
    // Any code other than the big-endian one is treated as little-endian.
    assign chip_big   = (r_q.opts.endian_select_field == `BOR_ENDIAN_BIG);
    assign region_big = cs_big_endian[access.cs];
    assign trusted_hit = r_q.opts.trusted_execute_only_memory && !access.external
                        && (access.block == `BOR_TRUSTED_BLOCK_A || access.block == `BOR_TRUSTED_BLOCK_B);

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r_q <= '0;
            r_q.state <= bor_pkg::BOR_HOLD;
            r_q.opts.endian_select_field <= `BOR_ENDIAN_LITTLE;
            r_q.status.detect <= 9'h002;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sys_reset          = (r_q.state != bor_pkg::BOR_RUN);
    assign pc_load            = r_q.pc_load;
    assign vector_addr        = `BOR_RESET_VECTOR;
    assign stack_ptr_load     = 1'b0;
    assign active_endian      = r_q.opts.endian_select_field;
    assign dbg_connected      = r_q.dbg_connected;
    assign id_refused         = r_q.id_refused;
    assign cmd_accept         = r_q.cmd_accept;
    assign cmd_refuse         = r_q.cmd_refuse;
    assign acc_done           = r_q.acc_done;
    assign acc_denied         = r_q.acc_denied;
    assign acc_big_endian     = r_q.acc_big_endian;
    assign acc_code_mismatch  = r_q.acc_code_mismatch;
    assign write_protect_register = r_q.write_protect_register;

    // Status zero: power-on, monitors 0..2, deep standby. One: cold/warm. Two: watchdogs, software.
    assign reset_status_zero = {3'h0, r_q.status.detect[`BOR_SRC_DSTBY], r_q.status.detect[`BOR_SRC_LVD2],
                                r_q.status.detect[`BOR_SRC_LVD1], r_q.status.detect[`BOR_SRC_LVD0],
                                r_q.status.detect[`BOR_SRC_POR]};
    assign reset_status_one  = {7'h00, r_q.status.cold_warm_start_flag};
    assign reset_status_two  = {5'h00, r_q.status.detect[`BOR_SRC_SW], r_q.status.detect[`BOR_SRC_WDT],
                                r_q.status.detect[`BOR_SRC_IWDT]};

endmodule // bor_ctrl

`default_nettype wire

// ---- bor_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Boot and reset control port checker
// ****************************************
module bor_monitor
(
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic [8:0]           reset_src,
    input wire bor_pkg::bor_access_t access,
    input wire logic                 id_valid,
    input wire logic                 cmd_valid,
    input wire logic                 swrst_wr,
    input wire logic [7:0]           cs_big_endian,
    input wire logic                 sys_reset,
    input wire logic                 pc_load,
    input wire logic [31:0]          vector_addr,
    input wire logic                 stack_ptr_load,
    input wire logic [2:0]           active_endian,
    input wire logic                 dbg_connected,
    input wire logic                 id_refused,
    input wire logic                 cmd_accept,
    input wire logic                 acc_done,
    input wire logic                 acc_denied,
    input wire logic                 acc_big_endian,
    input wire logic [7:0]           reset_status_one,
    input wire logic [7:0]           reset_status_two,
    input wire logic [7:0]           write_protect_register
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_quiet;
        reset_src == 9'h000 && !swrst_wr;
    endsequence
    // A lone source followed by eleven quiet cycles must end in the vector fetch.
    sequence s_src_then_quiet;
        (|reset_src) ##1 s_quiet[*8] ##1 s_quiet[*3];
    endsequence
    // The program counter load shows one cycle after the last quiet cycle of the hold and vector phases.
    AST_VECTOR_FETCH: assert property (s_src_then_quiet |=> pc_load) else $error("no vector fetch");
    AST_VECTOR_ADDR: assert property (vector_addr == 32'hFFFFFFFC) else $error("vector moved");
    AST_NO_SP_LOAD: assert property (stack_ptr_load == 1'b0) else $error("stack pointer loaded");
    AST_SRC_RESETS: assert property ((|reset_src) |=> sys_reset) else $error("source ignored");
    AST_IWDT_FLAG: assert property (reset_src == 9'h008 |=> reset_status_two[1:0] == 2'h1)
        else $error("watchdog flags wrong");
    AST_COLD_WARM_KEEP: assert property ($fell(reset_status_one[0]) |-> $past(reset_src[1]))
        else $error("warm flag lost");
    AST_SWRST_LOCK: assert property (!sys_reset && swrst_wr && !write_protect_register[1]
        && reset_src == 9'h000 |=> !sys_reset) else $error("locked reset taken");
    AST_ID_ANSWER: assert property (!sys_reset && id_valid && reset_src == 9'h000
        |=> dbg_connected != id_refused) else $error("id answer wrong");
    AST_CMD_GATE: assert property (cmd_accept |-> $past(cmd_valid && dbg_connected))
        else $error("command let through");
    AST_FETCH_LE: assert property (acc_done && $past(access.fetch) |-> !acc_big_endian)
        else $error("fetch not little");
    AST_CS_ENDIAN: assert property (acc_done && $past(access.external && !access.fetch)
        |-> acc_big_endian == $past(cs_big_endian[access.cs])) else $error("region order wrong");
    AST_TRUSTED_DENY: assert property (acc_done && acc_denied
        |-> $past(!access.external && access.block[3:1] == 3'h4 && (!access.fetch || access.outside)))
        else $error("bad deny");
    AST_OPT_HELD: assert property (!sys_reset && $past(!sys_reset) |-> $stable(active_endian))
        else $error("options moved");
endmodule // bor_monitor
bind bor_ctrl bor_monitor u_bor_monitor (.clk, .rst, .reset_src, .access, .id_valid, .cmd_valid, .swrst_wr,
    .cs_big_endian, .sys_reset, .pc_load, .vector_addr, .stack_ptr_load, .active_endian, .dbg_connected,
    .id_refused, .cmd_accept, .acc_done, .acc_denied, .acc_big_endian, .reset_status_one, .reset_status_two,
    .write_protect_register);
`default_nettype wire

// ---- bor_tool.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Debugger and programmer tool model
// ****************************************
module bor_tool
(
    input  wire logic         clk,
    output logic              id_valid,
    output logic [127:0]      id_code,
    output logic              cmd_valid
);
    initial
    begin
        id_valid = 1'b0;
        id_code = '0;
        cmd_valid = 1'b0;
    end
    // The code lines are inverted once released so a stale code can never match.
    task automatic connect(input logic [127:0] c);
        @(negedge clk);
        id_valid = 1'b1;
        id_code = c;
        @(negedge clk);
        id_valid = 1'b0;
        id_code = ~c;
    endtask
    task automatic command;
        @(negedge clk);
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask
endmodule // bor_tool
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "bor_consts.svh"
// ****************************************
// Boot and reset control testbench
// ****************************************
module tb;
    logic clk, rst, id_valid, cmd_valid, prot_wr, swrst_wr, cold_warm_wr, sys_reset, pc_load, spl, dbg, idr;
    logic cacc, cref, adone, aden, abe, amis;
    logic [8:0] reset_src, flag_clear;
    logic [7:0] cs_be, prot_wdata, st0, st1, st2, wpr;
    logic [127:0] id_code;
    logic [31:0] vaddr;
    logic [2:0] endian;
    logic [9:0] f;
    bor_pkg::bor_opts_t opt, opt_s;
    bor_pkg::bor_access_t acc;
    int n_fail, compares, i;
    localparam logic [8:0] CLR [9] = '{9'h000, `BOR_CLR_POR, `BOR_CLR_LVD0, `BOR_CLR_IWDT, `BOR_CLR_WDT,
        `BOR_CLR_LVD1, `BOR_CLR_LVD2, `BOR_CLR_DSTBY, `BOR_CLR_SW};
    localparam logic [8:0] CWC = `BOR_CLR_COLD_WARM;
    bor_tool u_bor_tool (.clk, .id_valid, .id_code, .cmd_valid);
    bor_ctrl u_bor_ctrl (.clk, .rst, .reset_src, .opt_mem(opt), .cs_big_endian(cs_be), .access(acc), .id_valid,
        .id_code, .cmd_valid, .prot_wr, .prot_wdata, .swrst_wr, .cold_warm_wr, .flag_clear, .sys_reset, .pc_load,
        .vector_addr(vaddr), .stack_ptr_load(spl), .active_endian(endian), .dbg_connected(dbg),
        .id_refused(idr), .cmd_accept(cacc), .cmd_refuse(cref), .acc_done(adone), .acc_denied(aden),
        .acc_big_endian(abe), .acc_code_mismatch(amis), .reset_status_zero(st0), .reset_status_one(st1),
        .reset_status_two(st2), .write_protect_register(wpr));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic finish_test;
        if (n_fail == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_run;
        int k;
        k = 0;
        while (sys_reset !== 1'b0 && k < 40)
        begin
            @(negedge clk);
            k++;
        end
        chk("run", k < 40, 1'b1);
        chk("pc", pc_load, 1'b1);
        chk("vec", vaddr, `BOR_RESET_VECTOR);
        chk("sp", spl, 1'b0);
        opt_s = opt;
    endtask
    // Flags model: clear by scope of the source, then set the source's own flag.
    function automatic logic [9:0] nxt(input logic [9:0] g, input int s);
        for (int k = 1; k < 9; k++) if (CLR[k][s]) g[k] = 1'b0;
        if (CWC[s]) g[9] = 1'b0;
        if (s > 0) g[s] = 1'b1;
        return g;
    endfunction
    task automatic fire(input logic [8:0] v, input int s);
        reset_src = v;
        cyc(1);
        reset_src = 9'h000;
        swrst_wr = 1'b0;
        wait_run();
        chk("wpr0", wpr, 8'h00);
        f = nxt(f, s);
        chk("st0", st0, {3'h0, f[7], f[6], f[5], f[2], f[1]});
        chk("st1", st1, {7'h0, f[9]});
        chk("st2", st2, {5'h0, f[8], f[4], f[3]});
        chk("dbg", dbg, 1'b0);
    endtask
    function automatic logic [2:0] aexp(input bor_pkg::bor_access_t a);
        logic ce;
        logic r;
        ce = opt_s.endian_select_field == 3'h0;
        r = cs_be[a.cs];
        return {opt_s.trusted_execute_only_memory & !a.external & (a.block == 4'h8 | a.block == 4'h9)
            & (!a.fetch | a.outside), !a.fetch & (a.external ? r : ce), a.fetch & a.external & (r != ce)};
    endfunction
    initial
    begin
        #100000;
        n_fail++;
        finish_test();
    end
    initial
    begin
        void'($urandom(32'h6AAAAF2C));
        {rst, reset_src, flag_clear, prot_wr, prot_wdata, swrst_wr, cold_warm_wr, acc, cs_be} = {1'b1, 48'h0};
        opt = {3'h0, 1'b1, $urandom, $urandom, $urandom, $urandom, 1'b1};
        f = 10'h002;
        cyc(5);
        rst = 1'b0;
        wait_run();
        chk("endian", endian, 3'h0);
        opt.endian_select_field = 3'h7;
        cyc(3);
        chk("held", endian, 3'h0);
        opt_s.endian_select_field = 3'h0;
        repeat (40)
        begin
            // Requests follow back to back, so valid stays up between them.
            acc = {1'b1, 6'($urandom), 4'h7 + 4'($urandom % 4)};
            cs_be = 8'($urandom);
            cyc(1);
            chk("done", adone, 1'b1);
            chk("acc", {aden, abe, amis}, aexp(acc));
        end
        acc.valid = 1'b0;
        u_bor_tool.connect(opt_s.debugger_id_code_store ^ (128'h1 << ($urandom % 128)));
        chk("refused", {idr, dbg}, 2'h2);
        u_bor_tool.command();
        chk("cmdref", {cref, cacc}, 2'h2);
        u_bor_tool.connect(opt_s.debugger_id_code_store);
        chk("conn", {idr, dbg}, 2'h1);
        u_bor_tool.command();
        chk("cmdacc", {cref, cacc}, 2'h1);
        cold_warm_wr = 1'b1;
        cyc(1);
        cold_warm_wr = 1'b0;
        f[9] = 1'b1;
        swrst_wr = 1'b1;
        cyc(1);
        swrst_wr = 1'b0;
        cyc(2);
        chk("locked", sys_reset, 1'b0);
        {prot_wr, prot_wdata} = 9'h102;
        cyc(1);
        prot_wr = 1'b0;
        chk("wpr", wpr, 8'h02);
        swrst_wr = 1'b1;
        fire(9'h000, 8);
        for (i = 8; i >= 0; i--) fire(9'h001 << i, i);
        repeat (8)
        begin
            i = $urandom % 9;
            fire(9'h001 << i, i);
        end
        fire(9'h118, 3);
        chk("endian2", endian, 3'h7);
        flag_clear = 9'h008;
        cyc(1);
        flag_clear = 9'h000;
        cyc(1);
        chk("cleared", st2[0], 1'b0);
        finish_test();
    end
endmodule // tb
`default_nettype wire
